// [rtl/hic_defines.vh]
// Register map, field positions and constants for the host port control
// Function
// - Chip reset clears every bit of the host port control register.
// - In ATAPI mode only control bits 7 to 5 have any effect.
// - Bits 7 to 5 mask command, end, decoder interrupts; flags unaffected.
// - Bit 4 low: host command FIFO write terminates data and status transfers.
// - A command break does not set the transfer end flag.
// - Bit 3 low: data transfer waits until status transfer completes.
// - Bit 2 low: status transfer waits until data transfer completes.
// - Bit 1 enables data transfers; writing 0 aborts the running one.
// - Bit 0 enables status transfers; writing 0 empties status FIFO, aborts.
// - In ATAPI mode only status bits 7 to 2 carry meaning.
// - ATAPI: command flag sets on selected command write or 90H; read clears.
// - Legacy: command flag high while command FIFO holds unread bytes.
// - Transfer end flag sets at transfer end; ack register write clears.
// - ATAPI: end flag also sets on packet received and memory transfer.
// - Decoder flag sets on new sector; block status three read clears.
// - Subcode flag sets on new subcode; subcode address high read clears.
// - Data busy sets on trigger register write, clears at transfer end.
// - ATAPI: soft reset flag sets on SRST write, unmasked; read clears.
// - Legacy: status busy sets on status FIFO write, clears when emptied.
// - Legacy: bits 1,0 mirror transfer pins, refreshed at host access end.
// - Status output path is a 12 entry byte FIFO filled by sub-CPU.
// - Legacy: reads of empty command FIFO return FFH.
`ifndef HIC_DEFINES_VH
`define HIC_DEFINES_VH

// ==========================================================
// Byte addresses
`define HIC_ADDR_W 6
`define HIC_OFS_CTRL 6'h00
`define HIC_OFS_STAT 6'h04
`define HIC_OFS_CMD_FIFO 6'h08
`define HIC_OFS_STAT_FIFO 6'h0c
`define HIC_OFS_TRIG 6'h10
`define HIC_OFS_ACK 6'h14
`define HIC_OFS_ATAPI_COMMAND_REG 6'h18
`define HIC_OFS_DEVCTL 6'h1c
`define HIC_OFS_BSTAT3 6'h20
`define HIC_OFS_SUBH 6'h24
`define HIC_OFS_MODE 6'h28

// ==========================================================
// Field positions
`define HIC_B_CMD 7
`define HIC_B_END 6
`define HIC_B_DEC 5
`define HIC_B_SUB 4
`define HIC_B_BRK 4
`define HIC_B_DBSY 3
`define HIC_B_DWAIT 3
`define HIC_B_SWAIT 2
`define HIC_B_SBSY 2
`define HIC_B_DOE 1
`define HIC_B_DPIN 1
`define HIC_B_SOE 0
`define HIC_B_SPIN 0
`define HIC_B_SRST 2

// ==========================================================
// Reset values and constants
`define HIC_CTRL_RST 8'h00
`define HIC_FIFO_DEPTH 12
`define HIC_PTR_W 4
`define HIC_PTR_LAST 4'hb
`define HIC_CNT_FULL 4'hc
`define HIC_EMPTY_READ 8'hff
`define HIC_DIAG_CMD 8'h90

`endif

// [rtl/hic_host_ctrl.v]
// Host port control and status registers with command and status FIFOs
`timescale 1ns/100ps
`include "hic_defines.vh"

module hic_host_ctrl (
    input wire mclk_in,
    input wire rst_in,
    input wire ce_in,
    // Avalon-MM slave
    input wire [5:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    output wire [31:0] avs_readdata_out,
    output wire avs_waitrequest_out,
    // Host side events, same clock
    input wire host_atapi_command_reg_wr_in,
    input wire host_drive_sel_in,
    input wire [7:0] host_atapi_command_reg_data_in,
    input wire host_devctl_wr_in,
    input wire [7:0] host_devctl_data_in,
    input wire host_cmd_fifo_wr_in,
    input wire [7:0] host_cmd_fifo_data_in,
    input wire host_stat_rd_in,
    input wire host_access_end_in,
    // Engine events
    input wire sector_ready_in,
    input wire subcode_ready_in,
    input wire xfer_done_in,
    input wire packet_done_in,
    input wire mem_xfer_done_in,
    // Outputs
    output wire [7:0] host_stat_data_out,
    output wire host_stat_valid_out,
    output wire host_cmd_full_out,
    output wire data_xfer_run_out,
    output wire data_xfer_abort_out,
    output wire data_xfer_pin_out,
    output wire status_xfer_pin_out,
    output wire sub_irq_out
);

    // ==========================================================
    // State
    reg [7:0] host_port_control_reg;
    reg atapi_mode_reg;
    reg command_flag_reg;
    reg xfer_end_flag_reg;
    reg decoder_flag_reg;
    reg subcode_flag_reg;
    reg data_xfer_busy_reg;
    reg soft_reset_flag_reg;
    reg status_xfer_busy_reg;
    reg data_pin_mirror_reg;
    reg status_pin_mirror_reg;

    reg [7:0] atapi_command_reg_value_reg;
    reg [7:0] devctl_value_reg;
    reg ack_reg;
    reg [31:0] rdata_reg;
    reg abort_reg;
    reg irq_reg;
    reg [7:0] stat_head_reg;

    reg [7:0] cmd_mem [0:`HIC_FIFO_DEPTH-1];
    reg [3:0] cmd_wp_reg;
    reg [3:0] cmd_rp_reg;
    reg [3:0] cmd_cnt_reg;
    reg [7:0] st_mem [0:`HIC_FIFO_DEPTH-1];
    reg [3:0] st_wp_reg;
    reg [3:0] st_rp_reg;
    reg [3:0] st_cnt_reg;

    // ==========================================================
    // Bus decode
    wire req = avs_read_in | avs_write_in;
    // A held request is taken once; ack masks its second edge
    wire acc = req & ~ack_reg & ce_in;
    wire wr = acc & avs_write_in;
    wire rd = acc & avs_read_in;
    wire wr_ctrl = wr & (avs_address_in == `HIC_OFS_CTRL);
    wire wr_stf = wr & (avs_address_in == `HIC_OFS_STAT_FIFO);
    wire wr_trig = wr & (avs_address_in == `HIC_OFS_TRIG);
    wire wr_ack = wr & (avs_address_in == `HIC_OFS_ACK);
    wire wr_mode = wr & (avs_address_in == `HIC_OFS_MODE);

    wire rd_cmdf = rd & (avs_address_in == `HIC_OFS_CMD_FIFO);
    wire rd_atapi_command_reg = rd & (avs_address_in == `HIC_OFS_ATAPI_COMMAND_REG);
    wire rd_devctl = rd & (avs_address_in == `HIC_OFS_DEVCTL);
    wire rd_bst3 = rd & (avs_address_in == `HIC_OFS_BSTAT3);
    wire rd_subh = rd & (avs_address_in == `HIC_OFS_SUBH);

    assign avs_waitrequest_out = req & ~ack_reg;
    assign avs_readdata_out = rdata_reg;

    // ==========================================================
    // Effective control, legacy bits ignored in ATAPI mode
    wire legacy = ~atapi_mode_reg;
    wire brk_en = legacy & ~host_port_control_reg[`HIC_B_BRK];
    wire dwait_en = legacy & ~host_port_control_reg[`HIC_B_DWAIT];
    wire swait_en = legacy & ~host_port_control_reg[`HIC_B_SWAIT];
    wire doe = atapi_mode_reg | host_port_control_reg[`HIC_B_DOE];
    wire soe = atapi_mode_reg | host_port_control_reg[`HIC_B_SOE];

    wire [7:0] wdata = avs_writedata_in[7:0];
    wire doe_off = wr_ctrl & legacy & ~wdata[`HIC_B_DOE];
    wire soe_off = wr_ctrl & legacy & ~wdata[`HIC_B_SOE];

    // Command break on host command FIFO write
    wire cmd_push = ce_in & legacy & host_cmd_fifo_wr_in &
        (cmd_cnt_reg != `HIC_CNT_FULL);

    wire cmd_break = ce_in & host_cmd_fifo_wr_in & brk_en;

    // ==========================================================
    // Transfer run and wait
    wire data_run = data_xfer_busy_reg &
        ~(dwait_en & status_xfer_busy_reg);
    wire stat_run = status_xfer_busy_reg &
        ~(swait_en & data_xfer_busy_reg);

    wire st_empty = (st_cnt_reg == 4'h0);
    wire st_pop = ce_in & legacy & host_stat_rd_in & stat_run & ~st_empty;
    wire st_push = wr_stf & legacy & soe &
        (st_cnt_reg != `HIC_CNT_FULL);
    wire st_last = st_pop & (st_cnt_reg == 4'h1);

    assign data_xfer_run_out = data_run;
    assign host_stat_valid_out = legacy & stat_run & ~st_empty;
    assign host_stat_data_out = stat_head_reg;
    assign host_cmd_full_out = (cmd_cnt_reg == `HIC_CNT_FULL);
    // Pins active low: low while transfer may proceed
    assign data_xfer_pin_out = ~data_run;
    assign status_xfer_pin_out = ~(legacy & stat_run);
    assign data_xfer_abort_out = abort_reg;
    assign sub_irq_out = irq_reg;

    // ==========================================================
    // Host end events
    wire atapi_command_reg_evt = ce_in & atapi_mode_reg & host_atapi_command_reg_wr_in &
        (host_drive_sel_in |
        (host_atapi_command_reg_data_in == `HIC_DIAG_CMD));
    wire srst_evt = ce_in & atapi_mode_reg & host_devctl_wr_in &
        host_devctl_data_in[`HIC_B_SRST];
    wire end_evt = ce_in & (xfer_done_in & data_xfer_busy_reg |
        atapi_mode_reg & (packet_done_in | mem_xfer_done_in));

    wire data_kill = cmd_break | doe_off;

    // ==========================================================
    // Status byte as read
    wire cmd_bit = atapi_mode_reg ? command_flag_reg :
        (cmd_cnt_reg != 4'h0);
    wire [7:0] status_byte = {
        cmd_bit,
        xfer_end_flag_reg,
        decoder_flag_reg,
        subcode_flag_reg,
        data_xfer_busy_reg,
        atapi_mode_reg ? soft_reset_flag_reg : status_xfer_busy_reg,
        legacy & data_pin_mirror_reg,
        legacy & status_pin_mirror_reg};

    reg [7:0] rd_byte;
    always @* begin
        case (avs_address_in)
            `HIC_OFS_CTRL: rd_byte = host_port_control_reg;
            `HIC_OFS_STAT: rd_byte = status_byte;
            `HIC_OFS_CMD_FIFO: rd_byte = (cmd_cnt_reg == 4'h0) ?
                `HIC_EMPTY_READ : cmd_mem[cmd_rp_reg];
            `HIC_OFS_ATAPI_COMMAND_REG: rd_byte = atapi_command_reg_value_reg;
            `HIC_OFS_DEVCTL: rd_byte = devctl_value_reg;
            `HIC_OFS_MODE: rd_byte = {7'h00, atapi_mode_reg};
            default: rd_byte = 8'h00;
        endcase
    end

    // ==========================================================
    // Bus answer and control registers
    always @(posedge mclk_in) begin
        if (rst_in) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            host_port_control_reg <= `HIC_CTRL_RST;
            atapi_mode_reg <= 1'b0;
            atapi_command_reg_value_reg <= 8'h00;
            devctl_value_reg <= 8'h00;
        end else if (ce_in) begin
            ack_reg <= req & ~ack_reg;
            if (rd) begin
                rdata_reg <= {24'h000000, rd_byte};
            end
            if (wr_ctrl) begin
                host_port_control_reg <= wdata;
            end
            if (wr_mode) begin
                atapi_mode_reg <= wdata[0];
            end
            if (ce_in & atapi_mode_reg & host_atapi_command_reg_wr_in) begin
                atapi_command_reg_value_reg <= host_atapi_command_reg_data_in;
            end
            if (ce_in & atapi_mode_reg & host_devctl_wr_in) begin
                devctl_value_reg <= host_devctl_data_in;
            end
        end
    end

    // ==========================================================
    // Sticky flags, set wins over clear
    always @(posedge mclk_in) begin
        if (rst_in) begin
            command_flag_reg <= 1'b0;
            xfer_end_flag_reg <= 1'b0;
            decoder_flag_reg <= 1'b0;
            subcode_flag_reg <= 1'b0;
            soft_reset_flag_reg <= 1'b0;
        end else if (ce_in) begin
            if (atapi_command_reg_evt) begin
                command_flag_reg <= 1'b1;
            end else if (rd_atapi_command_reg) begin
                command_flag_reg <= 1'b0;
            end
            // Break and aborts never reach end_evt
            if (end_evt) begin
                xfer_end_flag_reg <= 1'b1;
            end else if (wr_ack) begin
                xfer_end_flag_reg <= 1'b0;
            end
            if (sector_ready_in) begin
                decoder_flag_reg <= 1'b1;
            end else if (rd_bst3) begin
                decoder_flag_reg <= 1'b0;
            end
            if (subcode_ready_in) begin
                subcode_flag_reg <= 1'b1;
            end else if (rd_subh) begin
                subcode_flag_reg <= 1'b0;
            end
            if (srst_evt) begin
                soft_reset_flag_reg <= 1'b1;
            end else if (rd_devctl) begin
                soft_reset_flag_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Interrupt and abort, one cycle behind their causes
    wire [2:0] irq_src = status_byte[7:5] & host_port_control_reg[7:5];
    wire irq_next = (|irq_src) |
        (atapi_mode_reg & soft_reset_flag_reg);
    wire abort_next = data_kill & data_xfer_busy_reg;

    // ==========================================================
    // Transfer busy bits, abort and interrupt
    always @(posedge mclk_in) begin
        if (rst_in) begin
            data_xfer_busy_reg <= 1'b0;
            status_xfer_busy_reg <= 1'b0;
            abort_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else if (ce_in) begin
            if (data_kill) begin
                data_xfer_busy_reg <= 1'b0;
            end else if (wr_trig & doe) begin
                data_xfer_busy_reg <= 1'b1;
            end else if (xfer_done_in) begin
                data_xfer_busy_reg <= 1'b0;
            end
            if (cmd_break | soe_off | atapi_mode_reg) begin
                status_xfer_busy_reg <= 1'b0;
            end else if (st_push) begin
                status_xfer_busy_reg <= 1'b1;
            end else if (st_last) begin
                status_xfer_busy_reg <= 1'b0;
            end
            abort_reg <= abort_next;
            irq_reg <= irq_next;
        end
    end

    // Pin mirrors, refreshed at the end of each host access
    always @(posedge mclk_in) begin
        if (rst_in) begin
            data_pin_mirror_reg <= 1'b1;
            status_pin_mirror_reg <= 1'b1;
        end else if (ce_in & host_access_end_in) begin
            data_pin_mirror_reg <= data_xfer_pin_out;
            status_pin_mirror_reg <= status_xfer_pin_out;
        end
    end

    // ==========================================================
    // Command FIFO, host fills, sub-CPU drains
    wire cmd_pop = rd_cmdf & legacy & (cmd_cnt_reg != 4'h0);

    always @(posedge mclk_in) begin
        if (rst_in) begin
            cmd_wp_reg <= 4'h0;
            cmd_rp_reg <= 4'h0;
            cmd_cnt_reg <= 4'h0;
        end else if (ce_in) begin
            if (atapi_mode_reg) begin
                cmd_wp_reg <= 4'h0;
                cmd_rp_reg <= 4'h0;
                cmd_cnt_reg <= 4'h0;
            end else begin
                if (cmd_push) begin
                    cmd_mem[cmd_wp_reg] <= host_cmd_fifo_data_in;
                    cmd_wp_reg <= (cmd_wp_reg == `HIC_PTR_LAST) ?
                        4'h0 : cmd_wp_reg + 4'h1;
                end
                if (cmd_pop) begin
                    cmd_rp_reg <= (cmd_rp_reg == `HIC_PTR_LAST) ?
                        4'h0 : cmd_rp_reg + 4'h1;
                end
                if (cmd_push & ~cmd_pop) begin
                    cmd_cnt_reg <= cmd_cnt_reg + 4'h1;
                end else if (cmd_pop & ~cmd_push) begin
                    cmd_cnt_reg <= cmd_cnt_reg - 4'h1;
                end
            end
        end
    end

    // ==========================================================
    // Status FIFO, sub-CPU fills, host drains
    wire st_flush = cmd_break | soe_off | atapi_mode_reg;
    wire [3:0] st_rp_nx = (st_rp_reg == `HIC_PTR_LAST) ?
        4'h0 : st_rp_reg + 4'h1;

    // Head byte follows the read pointer; a push that meets the
    // last pop in one cycle goes straight to the head
    reg [7:0] stat_head_next;
    always @* begin
        stat_head_next = stat_head_reg;
        if (st_push & (st_empty | st_last)) begin
            stat_head_next = wdata;
        end else if (st_pop & (st_cnt_reg > 4'h1)) begin
            stat_head_next = st_mem[st_rp_nx];
        end
    end

    always @(posedge mclk_in) begin
        if (rst_in) begin
            st_wp_reg <= 4'h0;
            st_rp_reg <= 4'h0;
            st_cnt_reg <= 4'h0;
            stat_head_reg <= 8'h00;
        end else if (ce_in) begin
            if (st_flush) begin
                st_wp_reg <= 4'h0;
                st_rp_reg <= 4'h0;
                st_cnt_reg <= 4'h0;
            end else begin
                if (st_push) begin
                    st_mem[st_wp_reg] <= wdata;
                    st_wp_reg <= (st_wp_reg == `HIC_PTR_LAST) ?
                        4'h0 : st_wp_reg + 4'h1;
                end
                if (st_pop) begin
                    st_rp_reg <= st_rp_nx;
                end
                if (st_push & ~st_pop) begin
                    st_cnt_reg <= st_cnt_reg + 4'h1;
                end else if (st_pop & ~st_push) begin
                    st_cnt_reg <= st_cnt_reg - 4'h1;
                end
            end
            stat_head_reg <= stat_head_next;
        end
    end

endmodule

// [test/hic_host_sva.sv]
// Assertions for the host port control block
`timescale 1ns/100ps
module hic_host_sva (
    input wire mclk_in,
    input wire rst_in,
    input wire ce_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_readdata_out,
    input wire avs_waitrequest_out,
    input wire xfer_done_in,
    input wire host_stat_valid_out,
    input wire host_cmd_full_out,
    input wire data_xfer_run_out,
    input wire data_xfer_abort_out,
    input wire data_xfer_pin_out,
    input wire status_xfer_pin_out,
    input wire sub_irq_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    // ==========================================
    // Properties
    chk_reset_quiet: assert property ($fell(rst_in) |->
        !sub_irq_out && data_xfer_pin_out && status_xfer_pin_out
        && !host_stat_valid_out && !data_xfer_run_out)
        else $error("outputs not idle after reset");
    chk_wait_one: assert property ((avs_read_in || avs_write_in) && ce_in
        && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("waitrequest longer than one cycle");
    chk_idle_nowait: assert property (!avs_read_in && !avs_write_in
        |-> !avs_waitrequest_out)
        else $error("waitrequest without request");
    chk_rdata_upper: assert property (avs_read_in && !avs_waitrequest_out
        |-> avs_readdata_out[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    chk_data_pin: assert property (data_xfer_run_out |->
        !data_xfer_pin_out) else $error("data pin high while running");
    chk_stat_pin: assert property (!status_xfer_pin_out |->
        host_stat_valid_out) else $error("status pin low with queue empty");
    chk_abort_pulse: assert property (data_xfer_abort_out |->
        !data_xfer_run_out ##1 !data_xfer_abort_out)
        else $error("abort pulse wrong");
    chk_done_stops: assert property (data_xfer_run_out && xfer_done_in
        && ce_in |=> !data_xfer_run_out) else $error("run after done");
    chk_full_holds: assert property (host_cmd_full_out && !avs_read_in
        && !avs_write_in |=> host_cmd_full_out)
        else $error("full command queue lost bytes");
endmodule

bind hic_host_ctrl hic_host_sva i_hic_host_sva (.mclk_in(mclk_in),
    .rst_in(rst_in), .ce_in(ce_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .xfer_done_in(xfer_done_in),
    .host_stat_valid_out(host_stat_valid_out),
    .host_cmd_full_out(host_cmd_full_out),
    .data_xfer_run_out(data_xfer_run_out),
    .data_xfer_abort_out(data_xfer_abort_out),
    .data_xfer_pin_out(data_xfer_pin_out),
    .status_xfer_pin_out(status_xfer_pin_out), .sub_irq_out(sub_irq_out));

// [test/hic_host_model.sv]
// Host computer model: register writes, command bytes, status reads
`timescale 1ns/100ps
module hic_host_model (
    input wire mclk_in,
    input wire stat_valid_in,
    input wire drain_en_in,
    output reg stat_rd_out,
    output reg atapi_command_reg_wr_out,
    output reg drive_sel_out,
    output reg [7:0] atapi_command_reg_data_out,
    output reg devctl_wr_out,
    output reg [7:0] devctl_data_out,
    output reg cmd_wr_out,
    output reg [7:0] cmd_data_out,
    output reg access_end_out
);
    reg [1:0] gap_reg = 2'h0;
    initial begin
        {atapi_command_reg_wr_out, drive_sel_out, devctl_wr_out} = 3'h0;
        {cmd_wr_out, access_end_out} = 2'h0;
        {atapi_command_reg_data_out, devctl_data_out, cmd_data_out} = 24'h0;
    end
    // Slow reader, at most one status byte every fourth cycle
    always @(posedge mclk_in) begin
        gap_reg <= gap_reg + 2'h1;
        stat_rd_out <= drain_en_in && stat_valid_in && gap_reg == 2'h0;
    end
    // Kind 0 command byte, 1 command reg, 2 device control, 3 access end
    task op(input [1:0] kind, input [7:0] d, input sel);
        begin
            @(posedge mclk_in);
            drive_sel_out <= sel;
            atapi_command_reg_wr_out <= kind == 2'h1;
            devctl_wr_out <= kind == 2'h2;
            cmd_wr_out <= kind == 2'h0;
            access_end_out <= kind == 2'h3;
            {atapi_command_reg_data_out, devctl_data_out, cmd_data_out} <= {d, d, d};
            @(posedge mclk_in);
            {atapi_command_reg_wr_out, devctl_wr_out, cmd_wr_out, access_end_out} <= 4'h0;
            {atapi_command_reg_data_out, devctl_data_out, cmd_data_out} <= ~{d, d, d};
        end
    endtask
endmodule

// [test/host_interface_control_status_tb_top.sv]
// Self-checking bench for the host port control block
`timescale 1ns/100ps
module host_interface_control_status_tb_top;
    reg mclk_in = 1'b0;
    reg rst_in = 1'b1;
    reg [5:0] adr = 6'h00;
    reg rd = 1'b0;
    reg wr = 1'b0;
    reg [31:0] wdat = 32'h0;
    reg [4:0] eng = 5'h0;
    reg drain = 1'b0;
    reg ce = 1'b1;
    reg [7:0] b;
    reg [7:0] cq [$];
    reg [7:0] exp_rd [$];
    reg [7:0] exp_st [$];
    wire [31:0] rdat;
    wire [7:0] sdat, adat, ddat, cdat;
    wire wreq, srd, awr, dsel, dwr, cwr, aend;
    wire [6:0] pins;
    integer err_total = 0, total_checks = 0, seed = 95, i, tmo = 0;
    always #20 mclk_in = ~mclk_in;
    hic_host_ctrl i_hic_host_ctrl (.mclk_in(mclk_in), .rst_in(rst_in),
        .ce_in(ce), .avs_address_in(adr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdat), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wreq), .host_atapi_command_reg_wr_in(awr),
        .host_drive_sel_in(dsel), .host_atapi_command_reg_data_in(adat),
        .host_devctl_wr_in(dwr), .host_devctl_data_in(ddat),
        .host_cmd_fifo_wr_in(cwr), .host_cmd_fifo_data_in(cdat),
        .host_stat_rd_in(srd), .host_access_end_in(aend),
        .sector_ready_in(eng[0]), .subcode_ready_in(eng[1]),
        .xfer_done_in(eng[2]), .packet_done_in(eng[3]),
        .mem_xfer_done_in(eng[4]), .host_stat_data_out(sdat),
        .host_stat_valid_out(pins[5]), .host_cmd_full_out(pins[6]),
        .data_xfer_run_out(pins[0]), .data_xfer_abort_out(pins[1]),
        .data_xfer_pin_out(pins[2]), .status_xfer_pin_out(pins[3]),
        .sub_irq_out(pins[4]));
    hic_host_model i_hic_host_model (.mclk_in(mclk_in),
        .stat_valid_in(pins[5]), .drain_en_in(drain), .stat_rd_out(srd),
        .atapi_command_reg_wr_out(awr), .drive_sel_out(dsel), .atapi_command_reg_data_out(adat),
        .devctl_wr_out(dwr), .devctl_data_out(ddat), .cmd_wr_out(cwr),
        .cmd_data_out(cdat), .access_end_out(aend));
    // ==========================================
    // Tasks
    task cmp(input string nm, input [7:0] e, input [7:0] g);
        begin
            total_checks = total_checks + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // Pin k must reach v within lim cycles
    task ex(input integer k, input v, input integer lim);
        integer n;
        begin
            n = 0;
            @(negedge mclk_in);
            while (pins[k] !== v && n < lim) begin
                n = n + 1;
                @(negedge mclk_in);
            end
            cmp($sformatf("pin%0d", k), {7'h0, v}, {7'h0, pins[k]});
            @(posedge mclk_in);
        end
    endtask
    task bus(input rw, input [5:0] a, input [7:0] d);
        begin
            adr <= a;
            wdat <= {24'h0, d};
            rd <= rw;
            wr <= !rw;
            @(posedge mclk_in);
            while (wreq) @(posedge mclk_in);
            rd <= 1'b0;
            wr <= 1'b0;
            @(posedge mclk_in);
        end
    endtask
    task w(input [5:0] a, input [7:0] d);
        bus(1'b0, a, d);
    endtask
    task r(input [5:0] a, input [7:0] e);
        begin
            exp_rd.push_back(e);
            bus(1'b1, a, 8'h00);
        end
    endtask
    task pe(input integer k);
        begin
            eng <= 5'h01 << k;
            @(posedge mclk_in);
            eng <= 5'h00;
            @(posedge mclk_in);
        end
    endtask
    task hop(input [1:0] k, input [7:0] d, input s);
        i_hic_host_model.op(k, d, s);
    endtask
    task give_verdict;
        begin
            $display("checks %0d errors %0d", total_checks, err_total);
            if (err_total == 0 && total_checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    // ==========================================
    // Result watcher and timeout
    always @(posedge mclk_in) begin
        if (rd && !wreq)
            cmp("readdata", exp_rd.pop_front(), rdat[7:0]);
        if (srd && pins[5])
            cmp("status_byte", exp_st.pop_front(), sdat);
        tmo = tmo + 1;
        if (tmo == 20000) begin
            err_total = err_total + 1;
            give_verdict;
        end
    end
    // ==========================================
    // Scenarios
    initial begin
        repeat (10) @(posedge mclk_in);
        rst_in <= 1'b0;
        r(6'h00, 8'h00); r(6'h04, 8'h03); r(6'h3c, 8'h00);
        ce <= 1'b0; pe(0); ce <= 1'b1; r(6'h04, 8'h03);
        for (i = 0; i < 12; i = i + 1) begin
            b = 8'($random(seed));
            cq.push_back(b);
            hop(2'h0, b, 1'b0);
        end
        ex(6, 1'b1, 1); hop(2'h0, 8'h5a, 1'b0); r(6'h04, 8'h83);
        for (i = 0; i < 12; i = i + 1) r(6'h08, cq[i]);
        r(6'h08, 8'hff); r(6'h04, 8'h03);
        pe(0); repeat (3) @(posedge mclk_in); ex(4, 1'b0, 0);
        r(6'h04, 8'h23); w(6'h00, 8'h20); ex(4, 1'b1, 3);
        r(6'h20, 8'h00); ex(4, 1'b0, 3); r(6'h04, 8'h03);
        pe(1); r(6'h04, 8'h13); r(6'h24, 8'h00); r(6'h04, 8'h03);
        w(6'h00, 8'h0a); w(6'h10, 8'h00); ex(0, 1'b1, 3);
        ex(2, 1'b0, 0); r(6'h04, 8'h0b);
        pe(2); ex(0, 1'b0, 3); r(6'h04, 8'h43);
        w(6'h14, 8'h00); r(6'h04, 8'h03);
        w(6'h10, 8'h00); hop(2'h0, 8'h3c, 1'b0); ex(1, 1'b1, 3);
        r(6'h04, 8'h83); r(6'h08, 8'h3c);
        w(6'h00, 8'h1a); w(6'h10, 8'h00); hop(2'h0, 8'hc3, 1'b0);
        repeat (3) @(posedge mclk_in); ex(0, 1'b1, 0);
        w(6'h00, 8'h18); ex(0, 1'b0, 3);
        r(6'h08, 8'hc3); r(6'h04, 8'h03);
        w(6'h00, 8'h0d);
        for (i = 0; i < 4; i = i + 1) begin
            b = 8'($random(seed));
            exp_st.push_back(b);
            w(6'h0c, b);
        end
        ex(3, 1'b0, 1); ex(5, 1'b1, 0); r(6'h04, 8'h07);
        hop(2'h3, 8'h00, 1'b0); r(6'h04, 8'h06);
        drain <= 1'b1;
        ex(5, 1'b0, 40); ex(3, 1'b1, 2);
        drain <= 1'b0;
        r(6'h04, 8'h02); hop(2'h3, 8'h00, 1'b0); r(6'h04, 8'h03);
        for (i = 0; i < 3; i = i + 1) w(6'h0c, 8'(i));
        ex(5, 1'b1, 1); w(6'h00, 8'h0c); ex(5, 1'b0, 2);
        ex(3, 1'b1, 0); w(6'h00, 8'h0d); ex(5, 1'b0, 1);
        w(6'h00, 8'h0b); w(6'h10, 8'h00); ex(0, 1'b1, 3);
        b = 8'($random(seed));
        exp_st.push_back(b);
        w(6'h0c, b); ex(3, 1'b1, 2); r(6'h04, 8'h0f);
        pe(2); ex(3, 1'b0, 3); drain <= 1'b1;
        ex(5, 1'b0, 40); drain <= 1'b0; w(6'h14, 8'h00); r(6'h04, 8'h03);
        w(6'h00, 8'h07);
        exp_st.push_back(b);
        w(6'h0c, b); w(6'h10, 8'h00); ex(0, 1'b0, 2);
        drain <= 1'b1; ex(0, 1'b1, 40); drain <= 1'b0; pe(2);
        r(6'h04, 8'h43); w(6'h14, 8'h00);
        w(6'h28, 8'h01); w(6'h00, 8'h00);
        hop(2'h1, 8'h12, 1'b0); hop(2'h3, 8'h00, 1'b0); r(6'h04, 8'h00);
        hop(2'h1, 8'h90, 1'b0); r(6'h04, 8'h80);
        r(6'h18, 8'h90); r(6'h04, 8'h00);
        hop(2'h2, 8'h04, 1'b0); ex(4, 1'b1, 3); r(6'h04, 8'h04);
        r(6'h1c, 8'h04); ex(4, 1'b0, 3);
        w(6'h00, 8'h80); hop(2'h1, 8'h12, 1'b1); ex(4, 1'b1, 3);
        r(6'h18, 8'h12); ex(4, 1'b0, 3);
        pe(3); r(6'h04, 8'h40); w(6'h14, 8'h00);
        pe(4); r(6'h04, 8'h40); w(6'h14, 8'h00);
        w(6'h10, 8'h00); ex(0, 1'b1, 3); pe(2); ex(0, 1'b0, 3);
        repeat (4) @(posedge mclk_in);
        give_verdict;
    end
endmodule
